/* File: host_model.sv */
// Host controller model: service request pin and boot command handshake.
// Assumes commands are taken on the rising edge of sys_clk_i while ready is high.
`timescale 1ns/100ps
`include "power_seq_regs.svh"
module host_model (
    input wire logic sys_clk_i,
    input wire logic cmd_ready_i,
    input wire logic resp_valid_i,
    input wire logic [`DATA_W-1:0] resp_data_i,
    output logic service_request_in_o,
    output logic host_cmd_valid_o,
    output power_seq_pkg::cmd_type host_cmd_op_o,
    output logic [`ADDR_W-1:0] host_cmd_addr_o,
    output logic [`DATA_W-1:0] host_cmd_data_o
);
    import power_seq_pkg::*;

    initial begin
        service_request_in_o = 1'b0;
        host_cmd_valid_o = 1'b0;
        host_cmd_op_o = CMD_NOP;
        host_cmd_addr_o = 16'h0000;
        host_cmd_data_o = 32'h00000000;
    end

    // Boot select level
    task automatic set_srq(input logic v);
        @(posedge sys_clk_i);
        service_request_in_o <= v;
    endtask

    // Held until taken; released lines show inverted data
    task automatic send(input cmd_type op, input logic [15:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int n;
        n = 0;
        r = 32'hxxxxxxxx;
        @(posedge sys_clk_i);
        host_cmd_valid_o <= 1'b1;
        host_cmd_op_o <= op;
        host_cmd_addr_o <= a;
        host_cmd_data_o <= d;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (cmd_ready_i !== 1'b1 && n < 50);
        host_cmd_valid_o <= 1'b0;
        host_cmd_addr_o <= ~a;
        host_cmd_data_o <= ~d;
        if (op inside {[CMD_CPU_RD:CMD_DSPD_WR], CMD_VERSION}) begin
            n = 0;
            do begin
                @(posedge sys_clk_i);
                n++;
            end while (resp_valid_i !== 1'b1 && n < 50);
            if (resp_valid_i === 1'b1) r = resp_data_i;
        end
    endtask
endmodule

/* File: interval_timer.sv */
// Saturating interval timer; flags expiry after limit_i cycles.
// Assumes limit_i is at least one and stable while counting.
`timescale 1ns/100ps
module interval_timer #(
    parameter int unsigned W = 22
) (
    input wire logic sys_clk_i,
    input wire logic clear_i,
    input wire logic [W-1:0] limit_i,
    output logic expired_o
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge sys_clk_i) begin
        if (clear_i) begin
            cnt_reg <= '0;
            expired_o <= 1'b0;
        end else if (!expired_o) begin
            cnt_reg <= cnt_reg + 1'b1;
            expired_o <= (cnt_reg == limit_i - 1'b1);
        end
    end
endmodule

/* File: power_seq_pkg.sv */
// Types shared by the power state sequencer files.
// Assumes nothing beyond the constants header.
package power_seq_pkg;

    typedef enum logic [4:0] {
        ST_RESET  = 5'h01,
        ST_INIT   = 5'h02,
        ST_BOOT   = 5'h04,
        ST_ACTIVE = 5'h08,
        ST_SLEEP  = 5'h10
    } state_type;

    typedef enum logic [3:0] {
        CMD_NOP       = 4'h0,
        CMD_CPU_RD    = 4'h1,
        CMD_CPU_WR    = 4'h2,
        CMD_DSPP_RD   = 4'h3,
        CMD_DSPP_WR   = 4'h4,
        CMD_DSPD_RD   = 4'h5,
        CMD_DSPD_WR   = 4'h6,
        CMD_DSP_EN    = 4'h7,
        CMD_DSP_DIS   = 4'h8,
        CMD_START     = 4'h9,
        CMD_VERSION   = 4'ha,
        CMD_RESET     = 4'hb,
        CMD_PAD_MAP   = 4'hc,
        CMD_GO_ACTIVE = 4'hd
    } cmd_type;

    typedef enum logic [1:0] {
        MEM_CPU       = 2'h0,
        MEM_DSP_PROG  = 2'h1,
        MEM_DSP_DATA  = 2'h2
    } mem_sel_type;

endpackage

/* File: power_seq_regs.svh */
// Timing, pad map and width constants for the power state sequencer.
// Assumes a single 50 MHz system clock.
`ifndef POWER_SEQ_REGS_SVH
`define POWER_SEQ_REGS_SVH

`define SYS_CLK_KHZ 50000
`define POR_DELAY_MS 50
`define STARTUP_MAX_MS 60
`define CNT_W 22
`define BLOCK_COUNT 8
`define ADDR_W 16
`define DATA_W 32
`define PAD_COUNT 4
`define PAD_SEL_W 3
`define PAD_MAP_W 12
`define PAD_MAP_DEFAULT 12'h688
`define VER_W 16

`endif

/* File: power_state_sequencer.sv */
// Start-up and power state controller: reset, init, boot, active, sleep.
// Assumes pins arrive asynchronously; command and firmware inputs are on sys_clk_i.
//
// What this block does
// - Supply low, brownout (if enabled) or firmware reset force the reset state.
// - In reset every function is off; only the reset hold is asserted.
// - After the power-on settle delay, leave reset for init.
// - Init is entered only from reset.
// - Init measures supply, configures supplies, loads trim; other logic idle.
// - During init the processor runs from the low power oscillator.
// - In init, service request low stays; high moves to boot handler once configuration ends.
// - Boot handler starts the processor running the ROM loader.
// - Boot handler enables the serial slave port on four default pads.
// - Commands read and write processor, DSP program and DSP data memory.
// - A command enables or disables the DSP core.
// - A command starts execution at a host given address.
// - A command returns loader and hardware version identifiers.
// - A command resets the device back to the reset state.
// - A command reloads the pad switch matrix assignment.
// - Boot handler moves to active only on the host command.
// - Active is entered only from boot handler or from sleep.
// - In active, clock and supply are gated for idle blocks.
// - Sleep is entered from active only on the processor sleep command.
// - Sleep keeps retention power, slow oscillator, idle processor, optional crystal.
// - An interrupt in sleep returns to active.
// - Start-up interval stays under its bound, power-on delay included.
`timescale 1ns/100ps
`include "power_seq_regs.svh"
module power_state_sequencer #(
    parameter int unsigned POR_CYCLES = `POR_DELAY_MS * `SYS_CLK_KHZ,
    parameter int unsigned STARTUP_CYCLES = `STARTUP_MAX_MS * `SYS_CLK_KHZ,
    parameter int unsigned BLOCKS = `BLOCK_COUNT,
    parameter logic [`VER_W-1:0] BOOT_VERSION = 16'h0a01, // Arbitrary value
    parameter logic [`VER_W-1:0] HW_VERSION = 16'h0b02 // Arbitrary value
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic supply_low_i,
    input wire logic brownout_i,
    input wire logic brownout_resets_i,
    input wire logic fw_reset_req_i,
    input wire logic service_request_in_i,
    input wire logic supply_measured_i,
    input wire logic otp_load_done_i,
    input wire logic host_cmd_valid_i,
    input wire power_seq_pkg::cmd_type host_cmd_op_i,
    input wire logic [`ADDR_W-1:0] host_cmd_addr_i,
    input wire logic [`DATA_W-1:0] host_cmd_data_i,
    input wire logic mem_ack_i,
    input wire logic [`DATA_W-1:0] mem_rdata_i,
    input wire logic sleep_cmd_i,
    input wire logic wake_irq_i,
    input wire logic keep_xtal_i,
    input wire logic [BLOCKS-1:0] block_active_i,
    output power_seq_pkg::state_type state_o,
    output logic por_hold_o,
    output logic lpo_en_o,
    output logic cpu_clk_lpo_o,
    output logic xtal_en_o,
    output logic slow_osc_en_o,
    output logic supply_measure_o,
    output logic pmu_config_o,
    output logic otp_load_o,
    output logic startup_late_o,
    output logic cpu_run_o,
    output logic cpu_idle_o,
    output logic rom_boot_o,
    output logic spi_slave_en_o,
    output logic [`PAD_MAP_W-1:0] pad_map_o,
    output logic cmd_ready_o,
    output logic resp_valid_o,
    output logic [`DATA_W-1:0] resp_data_o,
    output logic mem_req_o,
    output power_seq_pkg::mem_sel_type mem_sel_o,
    output logic mem_we_o,
    output logic [`ADDR_W-1:0] mem_addr_o,
    output logic [`DATA_W-1:0] mem_wdata_o,
    output logic dsp_enable_o,
    output logic cpu_start_o,
    output logic [`ADDR_W-1:0] cpu_start_addr_o,
    output logic retention_pwr_o,
    output logic [BLOCKS-1:0] block_clk_en_o,
    output logic [BLOCKS-1:0] block_pwr_en_o
);
    import power_seq_pkg::*;

    function automatic logic is_mem_op(input cmd_type op);
        is_mem_op = (op inside {CMD_CPU_RD, CMD_CPU_WR, CMD_DSPP_RD, CMD_DSPP_WR,
                                CMD_DSPD_RD, CMD_DSPD_WR});
    endfunction

    function automatic mem_sel_type mem_sel_of(input cmd_type op);
        case (op)
            CMD_DSPP_RD, CMD_DSPP_WR: mem_sel_of = MEM_DSP_PROG;
            CMD_DSPD_RD, CMD_DSPD_WR: mem_sel_of = MEM_DSP_DATA;
            default: mem_sel_of = MEM_CPU;
        endcase
    endfunction

    state_type state_reg;
    state_type state_next;
    state_type state_d;
    logic supply_low_s;
    logic brownout_s;
    logic srq_s;
    logic por_done;
    logic startup_done;
    logic cfg_done;
    logic cmd_take;
    logic reset_req;
    logic mem_next;

    sync2 #(.W(3)) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i({supply_low_i, brownout_i, service_request_in_i}),
        .sync_o({supply_low_s, brownout_s, srq_s})
    );

    interval_timer #(.W(`CNT_W)) u_por_timer (
        .sys_clk_i(sys_clk_i),
        .clear_i(reset_req || state_reg != ST_RESET),
        .limit_i(`CNT_W'(POR_CYCLES)),
        .expired_o(por_done)
    );

    interval_timer #(.W(`CNT_W)) u_startup_timer (
        .sys_clk_i(sys_clk_i),
        .clear_i(reset_req),
        .limit_i(`CNT_W'(STARTUP_CYCLES)),
        .expired_o(startup_done)
    );

    assign cmd_take = host_cmd_valid_i && cmd_ready_o;
    // Any reset source overrides the state machine
    assign reset_req = rst_i || supply_low_s || (brownout_s && brownout_resets_i)
                       || fw_reset_req_i || (cmd_take && host_cmd_op_i == CMD_RESET);
    // Configuration ends when done or when the start-up bound runs out
    assign cfg_done = (supply_measured_i && otp_load_done_i) || startup_done;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: if (por_done) state_next = ST_INIT;
            ST_INIT: if (cfg_done && srq_s) state_next = ST_BOOT;
            ST_BOOT: if (cmd_take && host_cmd_op_i == CMD_GO_ACTIVE) state_next = ST_ACTIVE;
            ST_ACTIVE: if (sleep_cmd_i) state_next = ST_SLEEP;
            ST_SLEEP: if (wake_irq_i) state_next = ST_ACTIVE;
            default: state_next = ST_RESET;
        endcase
        state_d = reset_req ? ST_RESET : state_next;
    end

    always_ff @(posedge sys_clk_i) begin
        state_reg <= state_d;
        state_o <= state_d;
    end

    // Power, clock and processor controls follow the next state
    always_ff @(posedge sys_clk_i) begin
        por_hold_o <= (state_d == ST_RESET);
        lpo_en_o <= (state_d == ST_INIT) || (state_d == ST_BOOT);
        cpu_clk_lpo_o <= (state_d == ST_INIT) || (state_d == ST_BOOT);
        xtal_en_o <= (state_d == ST_BOOT) || (state_d == ST_ACTIVE)
                     || (state_d == ST_SLEEP && keep_xtal_i);
        slow_osc_en_o <= (state_d == ST_ACTIVE) || (state_d == ST_SLEEP);
        cpu_run_o <= (state_d == ST_BOOT) || (state_d == ST_ACTIVE);
        cpu_idle_o <= (state_d == ST_SLEEP);
        rom_boot_o <= (state_d == ST_BOOT);
        spi_slave_en_o <= (state_d == ST_BOOT) || (state_d == ST_ACTIVE);
        retention_pwr_o <= (state_d != ST_RESET);
    end

    // Init sequencing: measure supply, then load trim; supply configuration runs until configuration ends
    always_ff @(posedge sys_clk_i) begin
        supply_measure_o <= (state_d == ST_INIT) && !supply_measured_i;
        pmu_config_o <= (state_d == ST_INIT) && !cfg_done;
        otp_load_o <= (state_d == ST_INIT) && supply_measured_i && !otp_load_done_i;
        if (reset_req) begin
            startup_late_o <= 1'b0;
        end else if (state_reg == ST_INIT && startup_done
                     && !(supply_measured_i && otp_load_done_i)) begin
            startup_late_o <= 1'b1;
        end
    end

    // Per block gating in active mode
    genvar gi;
    generate
        for (gi = 0; gi < BLOCKS; gi++) begin : g_gate
            always_ff @(posedge sys_clk_i) begin
                block_clk_en_o[gi] <= (state_d == ST_ACTIVE) && block_active_i[gi];
                block_pwr_en_o[gi] <= (state_d == ST_ACTIVE) && block_active_i[gi];
            end
        end
    endgenerate

    // Boot command acceptance
    assign mem_next = (mem_req_o && !mem_ack_i) || (cmd_take && is_mem_op(host_cmd_op_i));

    always_ff @(posedge sys_clk_i) begin
        cmd_ready_o <= (state_d == ST_BOOT) && !mem_next;
    end

    // Memory access commands
    always_ff @(posedge sys_clk_i) begin
        if (reset_req) begin
            mem_req_o <= 1'b0;
            mem_sel_o <= MEM_CPU;
            mem_we_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= '0;
        end else if (cmd_take && is_mem_op(host_cmd_op_i)) begin
            mem_req_o <= 1'b1;
            mem_sel_o <= mem_sel_of(host_cmd_op_i);
            mem_we_o <= host_cmd_op_i inside {CMD_CPU_WR, CMD_DSPP_WR, CMD_DSPD_WR};
            mem_addr_o <= host_cmd_addr_i;
            mem_wdata_o <= host_cmd_data_i;
        end else if (mem_req_o && mem_ack_i) begin
            mem_req_o <= 1'b0;
        end
    end

    // Answers to the host
    always_ff @(posedge sys_clk_i) begin
        if (reset_req) begin
            resp_valid_o <= 1'b0;
            resp_data_o <= '0;
        end else if (mem_req_o && mem_ack_i) begin
            resp_valid_o <= 1'b1;
            resp_data_o <= mem_we_o ? '0 : mem_rdata_i;
        end else if (cmd_take && host_cmd_op_i == CMD_VERSION) begin
            resp_valid_o <= 1'b1;
            resp_data_o <= {BOOT_VERSION, HW_VERSION};
        end else begin
            resp_valid_o <= 1'b0;
        end
    end

    // DSP enable, start address and pad matrix
    always_ff @(posedge sys_clk_i) begin
        if (reset_req) begin
            dsp_enable_o <= 1'b0;
            cpu_start_o <= 1'b0;
            cpu_start_addr_o <= '0;
            pad_map_o <= `PAD_MAP_DEFAULT;
        end else begin
            cpu_start_o <= cmd_take && host_cmd_op_i == CMD_START;
            if (cmd_take && host_cmd_op_i == CMD_START) cpu_start_addr_o <= host_cmd_addr_i;
            if (cmd_take && host_cmd_op_i == CMD_DSP_EN) dsp_enable_o <= 1'b1;
            if (cmd_take && host_cmd_op_i == CMD_DSP_DIS) dsp_enable_o <= 1'b0;
            if (cmd_take && host_cmd_op_i == CMD_PAD_MAP) begin
                pad_map_o <= host_cmd_data_i[`PAD_MAP_W-1:0];
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_reset_any;
        reset_req |=> state_reg == ST_RESET && por_hold_o;
    endproperty
    a_reset_any: assert property (p_reset_any) else $error("reset source ignored");

    property p_reset_off;
        state_reg == ST_RESET |-> !cpu_run_o && !spi_slave_en_o && !xtal_en_o
            && !retention_pwr_o && block_clk_en_o == '0 && !mem_req_o;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("function on in reset");

    property p_por_exit;
        state_reg == ST_RESET && por_done && !reset_req |=> state_reg == ST_INIT;
    endproperty
    a_por_exit: assert property (p_por_exit) else $error("no init after settle");

    property p_init_entry;
        state_reg == ST_INIT && $past(state_reg) != ST_INIT |-> $past(state_reg) == ST_RESET;
    endproperty
    a_init_entry: assert property (p_init_entry) else $error("init entered wrongly");

    property p_srq_low;
        state_reg == ST_INIT && !srq_s && !reset_req |=> state_reg == ST_INIT ##1 1'b1;
    endproperty
    a_srq_low: assert property (p_srq_low) else $error("left init with request low");

    property p_srq_high;
        state_reg == ST_INIT && srq_s && cfg_done && !reset_req |=> state_reg == ST_BOOT
            && rom_boot_o && cpu_run_o && spi_slave_en_o;
    endproperty
    a_srq_high: assert property (p_srq_high) else $error("boot not entered");

    property p_go_active;
        state_reg == ST_ACTIVE && $past(state_reg) == ST_BOOT
            |-> $past(cmd_take && host_cmd_op_i == CMD_GO_ACTIVE);
    endproperty
    a_go_active: assert property (p_go_active) else $error("active without command");

    property p_active_entry;
        state_reg == ST_ACTIVE && $past(state_reg) != ST_ACTIVE
            |-> $past(state_reg) inside {ST_BOOT, ST_SLEEP};
    endproperty
    a_active_entry: assert property (p_active_entry) else $error("active from bad state");

    property p_sleep_entry;
        $rose(state_reg == ST_SLEEP) |-> $past(state_reg) == ST_ACTIVE && $past(sleep_cmd_i)
            && cpu_idle_o && retention_pwr_o;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered wrongly");

    property p_wake;
        state_reg == ST_SLEEP && wake_irq_i && !reset_req |=> state_reg == ST_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on interrupt");

    property p_gate;
        state_d == ST_ACTIVE |=> block_clk_en_o == $past(block_active_i)
            && block_pwr_en_o == $past(block_active_i);
    endproperty
    a_gate: assert property (p_gate) else $error("idle block not gated");

    property p_version;
        cmd_take && host_cmd_op_i == CMD_VERSION && !reset_req
            |=> resp_valid_o && resp_data_o == {BOOT_VERSION, HW_VERSION};
    endproperty
    a_version: assert property (p_version) else $error("version answer wrong");

    c_boot: cover property (state_reg == ST_INIT ##1 state_reg == ST_BOOT);
    c_active: cover property (state_reg == ST_BOOT ##1 state_reg == ST_ACTIVE);
    c_sleep_wake: cover property (state_reg == ST_SLEEP ##1 state_reg == ST_ACTIVE);
    c_mem_read: cover property (mem_req_o && mem_ack_i && !mem_we_o);
endmodule

/* File: power_state_sequencer_tb.sv */
// Self-checking bench for the power state sequencer with a host model.
// Assumes the memory side is answered by the bench's own responder.
`timescale 1ns/100ps
`include "power_seq_regs.svh"
module power_state_sequencer_tb;
    import power_seq_pkg::*;
    localparam int POR = 20;
    localparam int STUP = 60;
    localparam logic [15:0] BV = 16'h1357; // Arbitrary value
    localparam logic [15:0] HV = 16'h2468; // Arbitrary value
    localparam logic [11:0] PADS = {3'h3, 3'h2, 3'h1, 3'h0};
    logic sys_clk_i, rst_i, supply_low_i, brownout_i, brownout_resets_i, fw_reset_req_i;
    logic service_request_in_i, supply_measured_i, otp_load_done_i, host_cmd_valid_i;
    cmd_type host_cmd_op_i;
    logic [15:0] host_cmd_addr_i, mem_addr_o, cpu_start_addr_o;
    logic [31:0] host_cmd_data_i, mem_rdata_i, resp_data_o, mem_wdata_o, wd_seen;
    logic mem_ack_i, sleep_cmd_i, wake_irq_i, keep_xtal_i, we_seen;
    logic [7:0] block_active_i, block_clk_en_o, block_pwr_en_o;
    state_type state_o;
    mem_sel_type mem_sel_o, sel_seen;
    logic por_hold_o, lpo_en_o, cpu_clk_lpo_o, xtal_en_o, slow_osc_en_o, supply_measure_o;
    logic pmu_config_o, otp_load_o, startup_late_o, cpu_run_o, cpu_idle_o, rom_boot_o;
    logic spi_slave_en_o, cmd_ready_o, resp_valid_o, mem_req_o, mem_we_o, dsp_enable_o;
    logic cpu_start_o, retention_pwr_o;
    logic [11:0] pad_map_o;
    int n_fail = 0, tests_run = 0, cyc = 0, mem_delay = 0, mem_cnt = 0;

    power_state_sequencer #(.POR_CYCLES(POR), .STARTUP_CYCLES(STUP), .BOOT_VERSION(BV),
        .HW_VERSION(HV)) uut (.*);
    host_model hm (.sys_clk_i(sys_clk_i), .cmd_ready_i(cmd_ready_o),
        .resp_valid_i(resp_valid_o), .resp_data_i(resp_data_o),
        .service_request_in_o(service_request_in_i), .host_cmd_valid_o(host_cmd_valid_i),
        .host_cmd_op_o(host_cmd_op_i), .host_cmd_addr_o(host_cmd_addr_i),
        .host_cmd_data_o(host_cmd_data_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // Cycle ceiling
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    // Memory responder, optionally slow; idle data toggles
    always @(posedge sys_clk_i) begin
        mem_ack_i <= 1'b0;
        mem_rdata_i <= ~mem_rdata_i;
        if (mem_req_o === 1'b1 && mem_ack_i !== 1'b1) begin
            if (mem_cnt >= mem_delay) begin
                mem_ack_i <= 1'b1;
                mem_rdata_i <= {mem_addr_o, 14'h0000, mem_sel_o};
                sel_seen <= mem_sel_o;
                we_seen <= mem_we_o;
                wd_seen <= mem_wdata_o;
                mem_cnt <= 0;
            end else mem_cnt <= mem_cnt + 1;
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic pe;
        @(posedge sys_clk_i);
    endtask

    task automatic ne;
        @(negedge sys_clk_i);
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic wait_st(input state_type s, input int lim);
        int n;
        n = 0;
        ne();
        while (state_o !== s && n < lim) begin
            ne();
            n++;
        end
        chk(state_o, s);
    endtask

    task automatic boot_up;
        wait_st(ST_INIT, POR + 8);
        wait_st(ST_BOOT, 8);
    endtask

    task automatic t_init;
        wait_st(ST_INIT, POR + 8);
        chk({lpo_en_o, cpu_clk_lpo_o, xtal_en_o}, 3'b110);
        chk({supply_measure_o, pmu_config_o, otp_load_o, cpu_run_o}, 4'b1100);
        pe();
        supply_measured_i <= 1'b1;
        cyc_n(2);
        ne();
        chk({supply_measure_o, otp_load_o}, 2'b01);
        pe();
        otp_load_done_i <= 1'b1;
        cyc_n(4);
        ne();
        chk({state_o, pmu_config_o}, {ST_INIT, 1'b0});
        hm.set_srq(1'b1);
        ne();
        ne();
        ne();
        chk(state_o, ST_INIT);
        wait_st(ST_BOOT, 4);
        chk({rom_boot_o, cpu_run_o, spi_slave_en_o, cmd_ready_o, lpo_en_o}, 5'h1f);
        chk(pad_map_o, PADS);
    endtask

    task automatic t_cmds;
        logic [31:0] r;
        logic [15:0] a;
        hm.send(CMD_VERSION, 16'h0000, 32'h0, r);
        chk(r, {BV, HV});
        ne();
        chk(resp_valid_o, 0);
        for (int i = 0; i < 6; i++) begin
            a = 16'h1230 + 16'(i);
            mem_delay = 3 * (i % 2);
            hm.send(cmd_type'(i + 1), a, ~{16'h0, a}, r);
            chk(sel_seen, 32'(i / 2));
            chk(we_seen, 32'(i % 2));
            chk(r, (i % 2) ? 32'h0 : {a, 14'h0000, 2'(i / 2)});
            if (i % 2) chk(wd_seen, ~{16'h0, a});
        end
        hm.send(CMD_DSP_EN, 16'h0000, 32'h0, r);
        ne();
        chk(dsp_enable_o, 1);
        hm.send(CMD_DSP_DIS, 16'h0000, 32'h0, r);
        ne();
        chk(dsp_enable_o, 0);
        hm.send(CMD_START, 16'h0400, 32'h0, r);
        ne();
        chk({cpu_start_o, cpu_start_addr_o}, {1'b1, 16'h0400});
        ne();
        chk(cpu_start_o, 0);
        hm.send(CMD_PAD_MAP, 16'h0000, 32'h0000f0d1, r);
        ne();
        chk(pad_map_o, 12'h0d1);
        pe();
        sleep_cmd_i <= 1'b1;
        pe();
        sleep_cmd_i <= 1'b0;
        ne();
        chk(state_o, ST_BOOT);
        hm.send(CMD_RESET, 16'h0000, 32'h0, r);
        ne();
        chk({state_o, pad_map_o, por_hold_o}, {ST_RESET, PADS, 1'b1});
        boot_up();
    endtask

    task automatic t_power;
        logic [31:0] r;
        hm.send(CMD_GO_ACTIVE, 16'h0000, 32'h0, r);
        ne();
        chk({state_o, rom_boot_o, slow_osc_en_o}, {ST_ACTIVE, 2'b01});
        ne();
        chk(cmd_ready_o, 0);
        pe();
        block_active_i <= 8'ha5;
        cyc_n(2);
        ne();
        chk({block_clk_en_o, block_pwr_en_o}, 16'ha5a5);
        pe();
        sleep_cmd_i <= 1'b1;
        pe();
        sleep_cmd_i <= 1'b0;
        ne();
        chk({state_o, cpu_idle_o, retention_pwr_o, xtal_en_o}, {ST_SLEEP, 3'b110});
        chk({block_clk_en_o, cpu_run_o}, 9'h000);
        pe();
        keep_xtal_i <= 1'b1;
        pe();
        ne();
        chk(xtal_en_o, 1);
        pe();
        wake_irq_i <= 1'b1;
        pe();
        wake_irq_i <= 1'b0;
        ne();
        chk({state_o, cpu_idle_o}, {ST_ACTIVE, 1'b0});
    endtask

    task automatic t_resets;
        pe();
        brownout_i <= 1'b1;
        cyc_n(5);
        ne();
        chk(state_o, ST_ACTIVE);
        pe();
        brownout_resets_i <= 1'b1;
        wait_st(ST_RESET, 4);
        chk({por_hold_o, retention_pwr_o, slow_osc_en_o, cpu_run_o}, 4'b1000);
        pe();
        brownout_i <= 1'b0;
        boot_up();
        pe();
        fw_reset_req_i <= 1'b1;
        pe();
        fw_reset_req_i <= 1'b0;
        wait_st(ST_RESET, 3);
        boot_up();
        pe();
        supply_low_i <= 1'b1;
        supply_measured_i <= 1'b0;
        wait_st(ST_RESET, 4);
        cyc_n(POR + 5);
        ne();
        chk(state_o, ST_RESET);
        pe();
        supply_low_i <= 1'b0;
        wait_st(ST_INIT, POR + 8);
        cyc_n(STUP - POR - 15);
        ne();
        chk(state_o, ST_INIT);
        wait_st(ST_BOOT, 20);
        chk(startup_late_o, 1);
        pe();
        rst_i <= 1'b1;
        cyc_n(3);
        ne();
        chk({state_o, startup_late_o}, {ST_RESET, 1'b0});
    endtask

    initial begin
        rst_i = 1'b1;
        {supply_low_i, brownout_i, brownout_resets_i, fw_reset_req_i} = 4'h0;
        {supply_measured_i, otp_load_done_i, sleep_cmd_i, wake_irq_i, keep_xtal_i} = 5'h00;
        block_active_i = 8'h00;
        mem_ack_i = 1'b0;
        mem_rdata_i = 32'h0;
        cyc_n(16);
        ne();
        chk({state_o, por_hold_o, pad_map_o}, {ST_RESET, 1'b1, PADS});
        chk({cpu_run_o, retention_pwr_o, spi_slave_en_o, lpo_en_o}, 4'h0);
        pe();
        rst_i <= 1'b0;
        cyc_n(POR - 3);
        ne();
        chk(state_o, ST_RESET);
        t_init();
        t_cmds();
        t_power();
        t_resets();
        print_verdict();
    end
endmodule

/* File: sync2.sv */
// Two flip-flop synchroniser for pin levels.
// Assumes inputs are asynchronous to sys_clk_i.
`timescale 1ns/100ps
module sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule
